/* pkg/simd_fp_pkg.sv */
package simd_fp_pkg;

  // Storage shape
  localparam int NUM_REGS = 8;
  localparam int MANT_W = 64;
  localparam int EXP_W = 16;
  localparam int WIDE_W = 128;
  localparam int NUM_PORTS = 3;

  // Values after reset, and the all-valid tag word
  localparam logic [7:0] TAG_RESET = 8'h00;
  localparam logic [7:0] TAG_ALL_VALID = 8'hff;
  localparam logic [2:0] TOP_RESET = 3'h0;
  localparam logic [MANT_W-1:0] MANT_RESET = 64'h0;
  localparam logic [EXP_W-1:0] EXP_RESET = 16'h0;

  // Cycle counts of the operation path
  localparam logic [3:0] BASE_CYCLES = 4'h1;
  localparam logic [3:0] SWITCH_CYCLES = 4'h3;
  localparam logic [3:0] UNALIGNED_CYCLES = 4'h2;
  localparam logic [3:0] SPLIT_CYCLES = 4'h2;
  localparam logic [3:0] MISMATCH_CYCLES = 4'h2;

  // Address field positions
  localparam logic [3:0] WIDE_ALIGN_MASK = 4'hf;
  localparam logic [2:0] NARROW_ALIGN_MASK = 3'h7;
  localparam logic [5:0] LINE_LAST_FIT = 6'h38;

  // Core generations for the issue model
  localparam logic [1:0] GEN_NARROW_PATH = 2'h0;
  localparam logic [1:0] GEN_WIDE = 2'h1;
  localparam logic [1:0] GEN_ENHANCED = 2'h2;

  typedef enum logic [3:0] {
    op_pk_read = 4'h0,
    op_pk_write = 4'h1,
    op_fp_push = 4'h2,
    op_fp_pop = 4'h3,
    op_empty_state = 4'h4,
    op_load64 = 4'h5,
    op_load128 = 4'h6,
    op_unaligned_wide_move = 4'h7,
    op_byte_align = 4'h8
  } op_t;

  typedef enum logic [1:0] {
    fault_none = 2'h0,
    fault_stack_overflow = 2'h1,
    fault_stack_underflow = 2'h2,
    fault_misalign = 2'h3
  } fault_t;

  typedef enum logic [1:0] {
    st_idle = 2'h0,
    st_wait = 2'h1,
    st_done = 2'h2
  } state_t;

  typedef struct packed {
    op_t op;
    logic [2:0] idx;
    logic [31:0] addr;
    logic mismatch;
    logic [4:0] shift;
    logic [WIDE_W-1:0] opnd_a;
    logic [WIDE_W-1:0] opnd_b;
  } op_req_t;

  typedef struct packed {
    fault_t fault;
    logic [WIDE_W-1:0] data;
  } op_resp_t;

  typedef struct packed {
    logic valid;
    logic wide;
    logic shuffle;
  } lane_req_t;

endpackage

/* design/simd_fp_shared_regs.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Packed registers share stack entries' physical storage
// - Any packed register reference marks all tags valid
// - Empty-state op clears every tag valid bit
// - Stack push onto all-valid tags raises overflow
// - Packed to stack switch costs extra cycles
// - Misaligned wide load faults, unaligned move excepted
// - Unaligned wide move completes, possibly slower
// - Misaligned narrow access never faults, split slower
// - Type-mismatched wide use: same result, slower
// - Narrow-path core issues wide ops every two cycles
// - Newer core: three ports, one per cycle
// - Enhanced core: shuffle class one per cycle
// - Wide and stack ops mix without switch cost
module simd_fp_shared_regs
  import simd_fp_pkg::*;
#(
  parameter logic [1:0] CORE_GEN = GEN_ENHANCED
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic req_valid,
  output logic req_ready,
  input wire op_req_t req,
  output logic resp_valid,
  output op_resp_t resp,
  input wire lane_req_t [NUM_PORTS-1:0] lane_req,
  output logic [NUM_PORTS-1:0] lane_grant,
  output logic [NUM_REGS-1:0] tag_valid,
  output logic [2:0] stack_top,
  output logic packed_mode
);

  state_t state; // Operation sequencer
  logic [3:0] wait_cnt; // Remaining cycles of the held op
  op_req_t req_q; // Held request
  logic [NUM_REGS-1:0][MANT_W-1:0] mant_q; // Shared mantissa storage
  logic [NUM_REGS-1:0][EXP_W-1:0] exp_q; // Sign and exponent storage
  logic [NUM_PORTS-1:0] hold; // Per-port throughput hold

  logic accept; // Request taken this cycle
  logic done_now; // Held op completes this cycle
  logic is_fp_req; // Incoming op is a stack op
  logic is_wide_req; // Incoming op is a 128-bit op
  logic [3:0] next_lat; // Latency of the incoming op
  logic [2:0] push_top; // Slot a push would fill
  logic [2*WIDE_W-1:0] align_cat; // Shifted concatenation
  logic [WIDE_W-1:0] align_result; // Byte-align window
  fault_t next_fault; // Fault of the completing op
  logic [WIDE_W-1:0] next_data; // Data of the completing op
  logic pk_ref; // Completing op touches a packed register
  logic mant_wr; // Packed register write
  logic push_ok; // Push writes a slot
  logic pop_ok; // Pop frees a slot

  assign req_ready = (state == st_idle);
  assign accept = req_valid && req_ready;
  assign done_now = (state == st_wait) && (wait_cnt == 4'h0);
  assign push_top = stack_top - 3'h1;

  // Incoming op classification
  assign is_fp_req = (req.op == op_fp_push) || (req.op == op_fp_pop);
  assign is_wide_req = (req.op == op_load128) || (req.op == op_unaligned_wide_move) ||
                       (req.op == op_byte_align);

  // Latency of the incoming op
  always_comb begin
    next_lat = BASE_CYCLES;
    // Leaving packed use for stack use costs a switch
    if (is_fp_req && packed_mode) begin
      next_lat = next_lat + SWITCH_CYCLES;
    end
    // Unaligned move on misaligned data takes longer
    if (req.op == op_unaligned_wide_move && (req.addr[3:0] & WIDE_ALIGN_MASK) != 4'h0) begin
      next_lat = next_lat + UNALIGNED_CYCLES;
    end
    // Narrow access crossing a line boundary takes longer
    if (req.op == op_load64 && req.addr[5:0] > LINE_LAST_FIT) begin
      next_lat = next_lat + SPLIT_CYCLES;
    end
    // Type-mismatched wide use costs time, not correctness
    if (is_wide_req && req.mismatch) begin
      next_lat = next_lat + MISMATCH_CYCLES;
    end
  end

  // Sequencer: idle, count latency, present answer one cycle
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= st_idle;
      wait_cnt <= 4'h0;
    end else begin
      unique case (state)
        st_idle: begin
          if (accept) begin
            state <= st_wait;
            wait_cnt <= next_lat - 4'h1;
          end
        end
        st_wait: begin
          if (wait_cnt == 4'h0) begin
            state <= st_done;
          end else begin
            wait_cnt <= wait_cnt - 4'h1;
          end
        end
        st_done: begin
          state <= st_idle;
        end
        default: begin
          state <= st_idle;
        end
      endcase
    end
  end

  // Held request
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      req_q <= '0;
    end else if (accept) begin
      req_q <= req;
    end
  end

  // Byte-align window of {a, b}
  assign align_cat = {req_q.opnd_a, req_q.opnd_b} >> {req_q.shift, 3'h0};
  assign align_result = align_cat[WIDE_W-1:0];

  // Result and side effects of the completing op
  always_comb begin
    next_fault = fault_none;
    next_data = '0;
    pk_ref = 1'b0;
    mant_wr = 1'b0;
    push_ok = 1'b0;
    pop_ok = 1'b0;
    unique case (req_q.op)
      op_pk_read: begin
        pk_ref = 1'b1;
        next_data = {64'h0, mant_q[req_q.idx]};
      end
      op_pk_write, op_load64: begin
        pk_ref = 1'b1;
        mant_wr = 1'b1;
      end
      op_fp_push: begin
        // Push onto an occupied slot overflows
        if (tag_valid[push_top]) begin
          next_fault = fault_stack_overflow;
        end else begin
          push_ok = 1'b1;
        end
      end
      op_fp_pop: begin
        // Pop of an empty slot underflows
        if (!tag_valid[stack_top]) begin
          next_fault = fault_stack_underflow;
        end else begin
          pop_ok = 1'b1;
          next_data = {48'h0, exp_q[stack_top], mant_q[stack_top]};
        end
      end
      op_empty_state: begin
        next_data = '0;
      end
      op_load128: begin
        // Aligned move faults on misaligned address
        if ((req_q.addr[3:0] & WIDE_ALIGN_MASK) != 4'h0) begin
          next_fault = fault_misalign;
        end else begin
          next_data = req_q.opnd_a;
        end
      end
      op_unaligned_wide_move: begin
        next_data = req_q.opnd_a;
      end
      op_byte_align: begin
        next_data = align_result;
      end
      default: begin
        next_data = '0;
      end
    endcase
  end

  // Answer register
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      resp_valid <= 1'b0;
      resp <= '0;
    end else begin
      resp_valid <= done_now;
      if (done_now) begin
        resp.fault <= next_fault;
        resp.data <= next_data;
      end
    end
  end

  // Shared storage, one entry per register
  genvar e;
  generate
    for (e = 0; e < NUM_REGS; e++) begin : g_entry
      always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          mant_q[e] <= MANT_RESET;
          exp_q[e] <= EXP_RESET;
        end else if (done_now && mant_wr && req_q.idx == e) begin
          mant_q[e] <= req_q.opnd_a[MANT_W-1:0];
        end else if (done_now && push_ok && push_top == e) begin
          mant_q[e] <= req_q.opnd_a[MANT_W-1:0];
          exp_q[e] <= req_q.opnd_a[MANT_W+EXP_W-1:MANT_W];
        end
      end
    end
  endgenerate

  // Tag word
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tag_valid <= TAG_RESET;
    end else if (done_now) begin
      if (pk_ref) begin
        tag_valid <= TAG_ALL_VALID;
      end else if (req_q.op == op_empty_state) begin
        tag_valid <= TAG_RESET;
      end else if (push_ok) begin
        tag_valid[push_top] <= 1'b1;
      end else if (pop_ok) begin
        tag_valid[stack_top] <= 1'b0;
      end
    end
  end

  // Stack top pointer
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      stack_top <= TOP_RESET;
    end else if (done_now && push_ok) begin
      stack_top <= push_top;
    end else if (done_now && pop_ok) begin
      stack_top <= stack_top + 3'h1;
    end
  end

  // Packed-mode flag, drives the switch cost
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      packed_mode <= 1'b0;
    end else if (done_now) begin
      if (pk_ref) begin
        packed_mode <= 1'b1;
      end else if (req_q.op == op_empty_state || req_q.op == op_fp_push || req_q.op == op_fp_pop) begin
        packed_mode <= 1'b0;
      end
    end
  end

  // Issue ports, each with its own throughput hold
  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++) begin : g_port
      logic two_cycle; // Op needs a free cycle after it
      assign two_cycle = (CORE_GEN == GEN_NARROW_PATH && lane_req[p].wide) ||
                         (CORE_GEN == GEN_WIDE && lane_req[p].shuffle);
      assign lane_grant[p] = lane_req[p].valid && !hold[p];
      always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          hold[p] <= 1'b0;
        end else begin
          hold[p] <= lane_grant[p] && two_cycle;
        end
      end
      full_rate_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (CORE_GEN == GEN_ENHANCED && lane_req[p].valid) |-> lane_grant[p])
        else $error("enhanced core port stalled");
      half_rate_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (CORE_GEN == GEN_NARROW_PATH && lane_grant[p] && lane_req[p].wide) |=> !lane_grant[p])
        else $error("wide op issued back to back on narrow path");
    end
  endgenerate

  tags_set_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (done_now && (req_q.op == op_pk_read || req_q.op == op_pk_write)) |=> tag_valid == TAG_ALL_VALID)
    else $error("packed reference left a tag clear");

  empty_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (done_now && req_q.op == op_empty_state) |=> tag_valid == TAG_RESET && $stable(mant_q))
    else $error("empty-state did not clear tags or changed contents");

  stack_overflow_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (done_now && req_q.op == op_fp_push && tag_valid == TAG_ALL_VALID)
    |=> resp_valid && resp.fault == fault_stack_overflow)
    else $error("push onto full tags did not overflow");

  switch_cost_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (accept && req.op == op_fp_push && packed_mode) |=> (!resp_valid)[*4])
    else $error("stack op after packed use answered too soon");

  wide_misalign_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (done_now && req_q.op == op_load128 && req_q.addr[3:0] != 4'h0) |=> resp.fault == fault_misalign)
    else $error("misaligned wide load did not fault");

  umove_ok_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (done_now && req_q.op == op_unaligned_wide_move)
    |=> resp.fault == fault_none && resp.data == $past(req_q.opnd_a))
    else $error("unaligned move failed");

  narrow_nofault_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (done_now && req_q.op == op_load64) |=> resp.fault == fault_none && tag_valid == TAG_ALL_VALID)
    else $error("narrow access faulted");

  wide_no_switch_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (accept && req.op == op_load128 && !req.mismatch && req.addr[3:0] == 4'h0) |-> ##2 resp_valid)
    else $error("wide op paid a switch cost");

  byte_window_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (done_now && req_q.op == op_byte_align) |=> resp.data == $past(align_result))
    else $error("byte-align window wrong");

endmodule

/* verification/op_issuer.sv */
`timescale 1ns/1ps
module op_issuer
  import simd_fp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic go,
  input wire op_req_t cmd,
  input wire logic req_ready,
  output logic req_valid,
  output op_req_t req,
  output logic taken
);
  // Idle lines until the first request
  initial begin
    req_valid = 1'b0;
    req = '0;
    taken = 1'b0;
  end
  // Mark the edge on which the block took the request
  always @(posedge sys_clk) begin
    taken <= req_valid && req_ready;
  end
  // Hold the request until taken, then release with flipped lines
  always @(negedge sys_clk) begin
    if (taken) begin
      req_valid <= 1'b0;
      req <= ~req;
    end else if (go) begin
      req_valid <= 1'b1;
      req <= cmd;
    end
  end
endmodule

/* verification/simd_fp_shared_regs_tb.sv */
`timescale 1ns/1ps
module simd_fp_shared_regs_tb;
  import simd_fp_pkg::*;
  logic sys_clk, rst_b, req_valid, req_ready, resp_valid, packed_mode, go, taken;
  op_req_t req, cmd;
  op_resp_t resp, rsp;
  lane_req_t [NUM_PORTS-1:0] lane_req;
  logic [NUM_PORTS-1:0] lane_grant, lane_grant_narrow, lane_grant_wide;
  logic [NUM_REGS-1:0] tag_valid;
  logic [2:0] stack_top;
  int err_count, comparisons, cyc, n;
  // Operand patterns
  localparam logic [127:0] OPA = {2{64'h0123456789abcdef}};
  localparam logic [127:0] OPB = {4{32'h01234567}};
  localparam logic [127:0] PSH = {48'h0, 16'h4003, 64'h8877665544332211};
  localparam logic [127:0] BAL = {32'h89abcdef, {3{32'h01234567}}};

  simd_fp_shared_regs u_simd_fp_shared_regs (.sys_clk(sys_clk), .rst_b(rst_b), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .resp_valid(resp_valid), .resp(resp), .lane_req(lane_req),
    .lane_grant(lane_grant), .tag_valid(tag_valid), .stack_top(stack_top), .packed_mode(packed_mode));
  // Older cores share the op stream; only their issue ports are judged
  simd_fp_shared_regs #(.CORE_GEN(GEN_NARROW_PATH)) u_simd_fp_shared_regs_narrow (.sys_clk(sys_clk),
    .rst_b(rst_b), .req_valid(req_valid), .req_ready(), .req(req), .resp_valid(), .resp(),
    .lane_req(lane_req), .lane_grant(lane_grant_narrow), .tag_valid(), .stack_top(), .packed_mode());
  simd_fp_shared_regs #(.CORE_GEN(GEN_WIDE)) u_simd_fp_shared_regs_wide (.sys_clk(sys_clk),
    .rst_b(rst_b), .req_valid(req_valid), .req_ready(), .req(req), .resp_valid(), .resp(),
    .lane_req(lane_req), .lane_grant(lane_grant_wide), .tag_valid(), .stack_top(), .packed_mode());
  op_issuer u_op_issuer (.sys_clk(sys_clk), .go(go), .cmd(cmd), .req_ready(req_ready),
    .req_valid(req_valid), .req(req), .taken(taken));

  // Free running clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // Hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      summarize();
    end
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One operation; n counts edges from taking to answer
  task automatic do_op(input op_t op, input logic [31:0] ad, input logic mm, input logic [127:0] a);
    int k;
    @(negedge sys_clk);
    cmd <= '{op, 3'h3, ad, mm, 5'h4, a, OPB};
    go <= 1'b1;
    @(negedge sys_clk);
    go <= 1'b0;
    for (k = 0; k < 50 && taken !== 1'b1; k++) begin
      @(posedge sys_clk);
      #1;
    end
    n = 0;
    while (n < 50 && resp_valid !== 1'b1) begin
      @(negedge sys_clk);
      n++;
    end
    rsp = resp;
  endtask

  task automatic t_packed;
    check("tags at reset", tag_valid, TAG_RESET);
    do_op(op_pk_write, 32'h0, 1'b0, OPA);
    check("tags after write", tag_valid, TAG_ALL_VALID);
    check("mode", packed_mode, 1'b1);
    do_op(op_pk_read, 32'h0, 1'b0, '0);
    check("read data", rsp.data, {64'h0, OPA[63:0]});
    do_op(op_fp_push, 32'h0, 1'b0, PSH);
    check("push fault", rsp.fault, fault_stack_overflow);
    check("switch time", 128'(n), 128'h5);
    check("top kept", stack_top, 3'h0);
    $display("packed test done");
  endtask

  task automatic t_empty;
    do_op(op_empty_state, 32'h0, 1'b0, '0);
    check("tags cleared", tag_valid, TAG_RESET);
    do_op(op_fp_push, 32'h0, 1'b0, PSH);
    check("push fault", rsp.fault, fault_none);
    check("push time", 128'(n), 128'h2);
    check("top", stack_top, 3'h7);
    do_op(op_load128, 32'h40, 1'b0, OPA);
    do_op(op_fp_pop, 32'h0, 1'b0, '0);
    check("pop data", rsp.data, PSH);
    check("pop time", 128'(n), 128'h2);
    do_op(op_fp_pop, 32'h0, 1'b0, '0);
    check("empty pop", rsp.fault, fault_stack_underflow);
    do_op(op_pk_read, 32'h0, 1'b0, '0);
    check("contents kept", rsp.data, {64'h0, OPA[63:0]});
    $display("empty test done");
  endtask

  task automatic t_align;
    op_t ops[8] = '{op_load128, op_load128, op_unaligned_wide_move, op_unaligned_wide_move,
      op_load64, op_load64, op_load128, op_byte_align};
    logic [31:0] ads[8] = '{32'h10, 32'h14, 32'h14, 32'h20, 32'h3c, 32'h4, 32'h10, 32'h0};
    fault_t flt[8] = '{fault_none, fault_misalign, fault_none, fault_none,
      fault_none, fault_none, fault_none, fault_none};
    int lat[8] = '{2, 2, 4, 2, 4, 2, 4, 2};
    logic [127:0] dat[8] = '{OPA, '0, OPA, OPA, '0, '0, OPA, BAL};
    int i;
    for (i = 0; i < 8; i++) begin
      do_op(ops[i], ads[i], i == 6, OPA);
      check("fault", rsp.fault, flt[i]);
      check("time", 128'(n), 128'(lat[i]));
      if (i != 4 && i != 5) begin
        check("data", rsp.data, dat[i]);
      end
    end
    $display("align test done");
  endtask

  // Reset in mid-run after packed use drops the switch cost
  task automatic t_reset;
    check("mode before reset", packed_mode, 1'b1);
    @(negedge sys_clk);
    rst_b = 1'b0;
    repeat (2) @(negedge sys_clk);
    check("tags in reset", tag_valid, TAG_RESET);
    check("mode in reset", packed_mode, 1'b0);
    check("answer in reset", resp_valid, 1'b0);
    rst_b = 1'b1;
    do_op(op_fp_push, 32'h0, 1'b0, PSH);
    check("push after reset", rsp.fault, fault_none);
    check("push time after reset", 128'(n), 128'h2);
    check("top after reset", stack_top, 3'h7);
    $display("reset test done");
  endtask

  task automatic t_lanes;
    int j;
    @(negedge sys_clk);
    lane_req <= 9'h1ff;
    for (j = 0; j < 3; j++) begin
      @(negedge sys_clk);
      check("grant", lane_grant, 3'h7);
      check("grant narrow", lane_grant_narrow, j[0] ? 3'h7 : 3'h0);
      check("grant shuffle", lane_grant_wide, j[0] ? 3'h7 : 3'h0);
    end
    lane_req <= 9'h1b6;
    for (j = 0; j < 2; j++) begin
      @(negedge sys_clk);
      check("grant wide", lane_grant, 3'h7);
      check("grant narrow wide", lane_grant_narrow, j[0] ? 3'h0 : 3'h7);
      check("grant plain", lane_grant_wide, 3'h7);
    end
    $display("lane test done");
  endtask

  // Main sequence
  initial begin
    rst_b = 1'b0;
    go = 1'b0;
    cmd = '0;
    lane_req = '0;
    repeat (6) @(negedge sys_clk);
    rst_b = 1'b1;
    check("ready", req_ready, 1'b1);
    t_packed();
    t_empty();
    t_align();
    t_reset();
    t_lanes();
    summarize();
  end
endmodule
